/* include/otwdt_pkg.sv */
package otwdt_pkg;

    // Service port decode and key bytes
    localparam logic [7:0] OTW_SVC_ADDR = 8'ha6;
    localparam logic [7:0] OTW_KEY_FIRST = 8'h1e;
    localparam logic [7:0] OTW_KEY_SECOND = 8'he1;

    // Counter geometry
    localparam int OTW_CNT_W = 14;
    localparam int OTW_OVF_COUNT = 16383;

    // Machine cycle length in oscillator periods
    localparam logic [3:0] OTW_MCYC_6CLK = 4'h6;
    localparam logic [3:0] OTW_MCYC_12CLK = 4'hc;

    // Reset-out pulse length, in oscillator periods
    localparam int OTW_OSC_PERIOD_NS = 50;
    localparam int OTW_CLK_PERIOD_NS = 50;
    localparam int OTW_PULSE_6CLK_OSC = 98;
    localparam int OTW_PULSE_12CLK_OSC = 196;
    localparam int OTW_PULSE_6CLK_CYC_I =
        (OTW_PULSE_6CLK_OSC * OTW_OSC_PERIOD_NS + OTW_CLK_PERIOD_NS - 1) / OTW_CLK_PERIOD_NS;
    localparam int OTW_PULSE_12CLK_CYC_I =
        (OTW_PULSE_12CLK_OSC * OTW_OSC_PERIOD_NS + OTW_CLK_PERIOD_NS - 1) / OTW_CLK_PERIOD_NS;
    localparam logic [7:0] OTW_PULSE_6CLK_CYC = 8'(OTW_PULSE_6CLK_CYC_I);
    localparam logic [7:0] OTW_PULSE_12CLK_CYC = 8'(OTW_PULSE_12CLK_CYC_I);

    // Key sequence tracker
    typedef enum logic [0:0] {
        OTW_SEQ_IDLE,
        OTW_SEQ_GOT_FIRST
    } otw_seq_t;

    typedef struct packed {
        otw_seq_t seq;
        logic armed;
        logic [OTW_CNT_W-1:0] cnt;
        logic [3:0] pre;
        logic [7:0] pulse_cnt;
        logic pin_drv;
        logic pin_oe_n;
        logic chip_rst;
    } otw_state_t;

    localparam otw_state_t OTW_STATE_RST = '{
        seq: OTW_SEQ_IDLE, armed: 1'b0, cnt: '0, pre: 4'h0,
        pulse_cnt: 8'h00, pin_drv: 1'b0, pin_oe_n: 1'b1, chip_rst: 1'b0
    };

endpackage : otwdt_pkg

/* hdl/otwdt_top.sv */
`timescale 1ns/1ps
// Summary of operation
// RL1 - After reset the counter is stopped until the arming pair is written.
// RL2 - Writing 1E then E1 to the service port at A6 arms counting.
// RL3 - While armed the counter advances by one each machine cycle.
// RL4 - Once armed nothing disables it except a reset or its own overflow.
// RL5 - A 14-bit count reaching 3FFF overflows and issues a full chip reset.
// RL6 - While armed the same key pair restarts the counter from zero.
// RL7 - Software must restart the counter within every 16383 machine cycles.
// RL8 - Service port is write only; the count cannot be read or written.
// RL9 - Overflow drives the reset pin high for 98 or 196 oscillator periods.
// RL10 - Software should place the restart pair in periodically executed code.
// RL11 - A machine cycle is six or twelve oscillator periods by clock mode.
// RL12 - A first key followed by any value other than E1 or 1E abandons the sequence silently.
module otwdt_top
    import otwdt_pkg::*;
#(
    parameter int OVF_COUNT = OTW_OVF_COUNT
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Special function register write port
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    // Clock mode, high for 6-clock mode
    input wire logic mode_6clk_i,
    // Reset pin drive and chip reset
    output logic rst_pin_o,
    output logic rst_pin_oe_n_o,
    output logic chip_reset_o,
    // Status
    output logic armed_o
);

    localparam logic [OTW_CNT_W-1:0] CNT_LAST = OTW_CNT_W'(OVF_COUNT - 1);

    if (OVF_COUNT < 2 || OVF_COUNT > (1 << OTW_CNT_W) - 1) begin : g_bad_ovf
        $error("OVF_COUNT does not fit the counter");
    end

    otw_state_t q;
    otw_state_t next_q;
    logic svc_wr;
    logic tick;
    logic restart;
    logic ovf;
    logic [3:0] mcyc_len;

    function automatic logic [3:0] otw_mcyc(input logic six);
        otw_mcyc = six ? OTW_MCYC_6CLK : OTW_MCYC_12CLK;
    endfunction : otw_mcyc

    // RL8 write only decode
    assign svc_wr = sfr_wr_i && (sfr_addr_i == OTW_SVC_ADDR) && !q.pin_drv;
    assign mcyc_len = otw_mcyc(mode_6clk_i);
    // RL11 machine cycle tick
    assign tick = (q.pre >= mcyc_len - 4'h1);
    // RL2 ordered key pair
    assign restart = svc_wr && (q.seq == OTW_SEQ_GOT_FIRST) && (sfr_wdata_i == OTW_KEY_SECOND);
    // RL5 overflow detect
    assign ovf = q.armed && tick && (q.cnt == CNT_LAST) && !restart;

    always_comb begin
        next_q = q;
        next_q.chip_rst = 1'b0;
        next_q.pre = tick ? 4'h0 : q.pre + 4'h1;

        // RL12 sequence abandon
        if (svc_wr) begin
            if (sfr_wdata_i == OTW_KEY_FIRST) begin
                next_q.seq = OTW_SEQ_GOT_FIRST;
            end else begin
                next_q.seq = OTW_SEQ_IDLE;
            end
        end

        // RL6 restart from zero
        if (restart) begin
            next_q.armed = 1'b1;
            next_q.cnt = '0;
        end else if (ovf) begin
            // RL4 disarm on overflow
            next_q.armed = 1'b0;
            next_q.cnt = '0;
            next_q.seq = OTW_SEQ_IDLE;
            next_q.chip_rst = 1'b1;
            // RL9 pulse length select
            next_q.pin_drv = 1'b1;
            next_q.pulse_cnt = (mode_6clk_i ? OTW_PULSE_6CLK_CYC : OTW_PULSE_12CLK_CYC) - 8'h01;
        end else if (q.armed && tick) begin
            // RL3 count machine cycles
            next_q.cnt = q.cnt + 1'b1;
        end

        // RL9 pulse countdown
        if (q.pin_drv) begin
            if (q.pulse_cnt == 8'h00) begin
                next_q.pin_drv = 1'b0;
            end else begin
                next_q.pulse_cnt = q.pulse_cnt - 8'h01;
            end
        end
        next_q.pin_oe_n = !next_q.pin_drv;
    end

    // RL1 stopped after reset
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= OTW_STATE_RST;
        end else begin
            q <= next_q;
        end
    end

    assign rst_pin_o = q.pin_drv;
    assign rst_pin_oe_n_o = q.pin_oe_n;
    assign chip_reset_o = q.chip_rst;
    assign armed_o = q.armed;

    // RL1 no arming without pair
    a_stay_disarmed: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL1
        !q.armed && !restart |=> !q.armed)
        else $error("Watchdog armed without key pair");

    // RL2 first key tracked
    a_first_key: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL2
        svc_wr && sfr_wdata_i == OTW_KEY_FIRST && !ovf |=> q.seq == OTW_SEQ_GOT_FIRST)
        else $error("First key not tracked");

    // RL2 pair arms counter
    a_pair_arms: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL2
        sfr_wr_i && sfr_addr_i == OTW_SVC_ADDR && !q.pin_drv
        && q.seq == OTW_SEQ_GOT_FIRST && sfr_wdata_i == OTW_KEY_SECOND
        |=> q.armed && q.cnt == '0)
        else $error("Key pair did not arm and clear");

    // RL4 no disarm while armed
    a_no_disarm: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL4
        q.armed && !(tick && q.cnt == CNT_LAST) |=> q.armed)
        else $error("Watchdog disarmed without overflow");

    // RL3 step per cycle
    a_count_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL3
        q.armed && tick && !restart && q.cnt != CNT_LAST
        |=> q.cnt == $past(q.cnt) + 1'b1)
        else $error("Counter failed to step");

    // RL11 hold between ticks
    a_count_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL11
        !tick && !restart |=> q.cnt == $past(q.cnt))
        else $error("Counter moved between machine cycles");

    // RL11 six clock spacing
    a_tick_six: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL11
        tick && mode_6clk_i ##1 mode_6clk_i[*6]
        |-> tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3)
        && !$past(tick, 4) && !$past(tick, 5))
        else $error("Machine cycle not six clocks");

    // RL5 overflow resets chip
    a_ovf_reset: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL5
        q.armed && tick && q.cnt == CNT_LAST && !restart
        |=> chip_reset_o && !armed_o && rst_pin_o && !rst_pin_oe_n_o ##1 !chip_reset_o)
        else $error("Overflow did not reset chip");

    // RL9 pulse length start
    a_pulse_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL9
        $rose(q.pin_drv) |-> q.pulse_cnt == ($past(mode_6clk_i) ?
            OTW_PULSE_6CLK_CYC - 8'h01 : OTW_PULSE_12CLK_CYC - 8'h01))
        else $error("Reset pulse length wrong");

    // RL9 pulse does not end early
    a_pulse_end: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL9
        q.pin_drv && q.pulse_cnt != 8'h00 |=> q.pin_drv && q.pulse_cnt == $past(q.pulse_cnt) - 8'h01)
        else $error("Reset pulse ended early");

    // RL12 wrong second byte
    a_seq_abort: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL12
        svc_wr && q.seq == OTW_SEQ_GOT_FIRST && sfr_wdata_i != OTW_KEY_SECOND
        && sfr_wdata_i != OTW_KEY_FIRST && !ovf
        |=> q.seq == OTW_SEQ_IDLE && q.armed == $past(q.armed)
        && (q.cnt == $past(q.cnt) || q.cnt == $past(q.cnt) + 1'b1))
        else $error("Bad second byte not abandoned");

    // RL6 restart clears count
    a_restart_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL6
        q.armed && restart |=> q.cnt == '0 && q.armed)
        else $error("Restart did not clear counter");

    // RL11 twelve clock spacing
    a_tick_twelve: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL11
        tick && !mode_6clk_i ##1 (!mode_6clk_i)[*8] ##1 (!mode_6clk_i)[*4]
        |-> tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3) && !$past(tick, 4)
        && !$past(tick, 5) && !$past(tick, 6) && !$past(tick, 7) && !$past(tick, 8)
        && !$past(tick, 9) && !$past(tick, 10) && !$past(tick, 11))
        else $error("Machine cycle not twelve clocks");

    // RL9 pin released after pulse
    a_pulse_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL9
        q.pin_drv && q.pulse_cnt == 8'h00 |=> !rst_pin_o && rst_pin_oe_n_o)
        else $error("Reset pin not released");

    // RL9 writes locked out
    a_pulse_no_arm: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL9
        q.pin_drv |=> !q.armed)
        else $error("Armed during reset pulse");

    // RL5 chip reset source
    a_reset_source: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL5
        chip_reset_o |-> $past(q.armed) && $past(q.cnt) == CNT_LAST && rst_pin_o)
        else $error("Chip reset without overflow");

    // RL4 overflow clears state
    a_ovf_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL4
        chip_reset_o |-> !armed_o && q.cnt == '0 && q.seq == OTW_SEQ_IDLE)
        else $error("Overflow left state behind");

    // RL2 other addresses ignored
    a_other_addr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL2
        sfr_wr_i && sfr_addr_i != OTW_SVC_ADDR && !ovf |=> q.seq == $past(q.seq))
        else $error("Foreign write moved key sequence");

endmodule : otwdt_top

/* tb/otwdt_cpu_model.sv */
`timescale 1ns/1ps
module otwdt_cpu_model
    import otwdt_pkg::*;
(
    // Clock
    input wire logic core_clk_i,
    // Service port writes
    output logic sfr_wr_o,
    output logic [7:0] sfr_addr_o,
    output logic [7:0] sfr_wdata_o
);
    initial begin
        sfr_wr_o = 1'b0;
        sfr_addr_o = 8'h00;
        sfr_wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        sfr_wr_o <= 1'b1;
        sfr_addr_o <= a;
        sfr_wdata_o <= d;
        @(posedge core_clk_i);
        sfr_wr_o <= 1'b0;
        sfr_addr_o <= ~a;
        sfr_wdata_o <= ~d;
    endtask : wr
    task automatic service();
        wr(OTW_SVC_ADDR, OTW_KEY_FIRST);
        wr(OTW_SVC_ADDR, OTW_KEY_SECOND);
    endtask : service
endmodule : otwdt_cpu_model

/* tb/one_time_enabled_watchdog_tb_top.sv */
`timescale 1ns/1ps
module one_time_enabled_watchdog_tb_top
    import otwdt_pkg::*;
;
    localparam int OVF = 20;
    logic core_clk_i, rst_n_i, mode_6clk_i, sfr_wr, rst_pin_o, rst_pin_oe_n_o, chip_reset_o, armed_o;
    logic [7:0] sfr_addr, sfr_wdata;
    int fails, n_compared, n_ovf;
    otwdt_cpu_model cpu_u (.core_clk_i(core_clk_i), .sfr_wr_o(sfr_wr), .sfr_addr_o(sfr_addr),
        .sfr_wdata_o(sfr_wdata));
    otwdt_top #(.OVF_COUNT(OVF)) dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .sfr_wr_i(sfr_wr), .sfr_addr_i(sfr_addr), .sfr_wdata_i(sfr_wdata),
        .mode_6clk_i(mode_6clk_i), .rst_pin_o(rst_pin_o), .rst_pin_oe_n_o(rst_pin_oe_n_o),
        .chip_reset_o(chip_reset_o), .armed_o(armed_o));
    function automatic int mcyc(input logic m6);
        return m6 ? 6 : 12;
    endfunction : mcyc
    function automatic int pulse_len(input logic m6);
        return m6 ? OTW_PULSE_6CLK_OSC : OTW_PULSE_12CLK_OSC;
    endfunction : pulse_len
    function automatic logic [7:0] junk();
        return 8'($urandom_range(8'h20, 8'hdf));
    endfunction : junk
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            fails++;
            $display("BAD t=%0t %s", $time, msg);
        end
    endtask : check
    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    task automatic ovf_check(input logic m6);
        int n;
        int p;
        n = 0;
        p = 0;
        while (chip_reset_o !== 1'b1 && n < 5000) begin
            @(negedge core_clk_i);
            n++;
        end
        check(n >= (OVF - 1) * mcyc(m6) && n <= OVF * mcyc(m6) + 2, "overflow time");
        check(armed_o === 1'b0 && rst_pin_oe_n_o === 1'b0, "pulse start");
        while (rst_pin_o === 1'b1 && p < 400) begin
            @(negedge core_clk_i);
            p++;
        end
        check(p == pulse_len(m6), "pulse length");
        check(rst_pin_oe_n_o === 1'b1, "pin not released");
    endtask : ovf_check
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        if (chip_reset_o === 1'b1) begin
            n_ovf++;
        end
    end
    initial begin
        #1000000;
        fails++;
        $display("BAD t=%0t run hung", $time);
        complete_run();
    end
    initial begin
        int s;
        fails = 0;
        n_compared = 0;
        n_ovf = 0;
        rst_n_i = 1'b0;
        mode_6clk_i = 1'b1;
        s = $urandom(32'hcc839946);
        repeat (6) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (OVF * 12) @(negedge core_clk_i);
        check(armed_o === 1'b0 && rst_pin_oe_n_o === 1'b1 && n_ovf == 0, "not idle");
        cpu_u.wr(OTW_SVC_ADDR, OTW_KEY_SECOND);
        cpu_u.wr(OTW_SVC_ADDR, OTW_KEY_FIRST);
        cpu_u.wr(OTW_SVC_ADDR, junk());
        cpu_u.wr(OTW_SVC_ADDR, OTW_KEY_SECOND);
        cpu_u.wr(8'ha7, OTW_KEY_FIRST);
        cpu_u.wr(8'ha7, OTW_KEY_SECOND);
        @(negedge core_clk_i);
        check(armed_o === 1'b0, "armed by bad keys");
        cpu_u.service();
        @(negedge core_clk_i);
        check(armed_o === 1'b1, "not armed");
        ovf_check(1'b1);
        check(n_ovf == 1, "overflow count");
        @(posedge core_clk_i);
        mode_6clk_i <= 1'b0;
        cpu_u.service();
        for (int i = 0; i < 8; i++) begin
            repeat ($urandom_range(1, (OVF - 2) * 12)) @(posedge core_clk_i);
            cpu_u.wr(OTW_SVC_ADDR, junk());
            cpu_u.service();
        end
        @(negedge core_clk_i);
        check(armed_o === 1'b1 && n_ovf == 1, "restart or disable");
        ovf_check(1'b0);
        cpu_u.service();
        repeat ($urandom_range(5, 60)) @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        @(negedge core_clk_i);
        check(armed_o === 1'b0 && rst_pin_oe_n_o === 1'b1, "armed in reset");
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (OVF * 12) @(negedge core_clk_i);
        check(armed_o === 1'b0 && n_ovf == 2, "armed after reset");
        complete_run();
    end
endmodule : one_time_enabled_watchdog_tb_top
